// file: pkg/pfif_regs.svh
// Register offsets, field positions and reset values of the fault/filter block
`ifndef PFIF_REGS_SVH
`define PFIF_REGS_SVH

// ****************************************************************
// Offsets (byte addresses)
// ****************************************************************
`define PFIF_OFS_STATUS 8'h74
`define PFIF_OFS_CHAN_FILT 8'h78
`define PFIF_OFS_FAULT_CTRL 8'h7c
`define PFIF_OFS_MODE 8'h80

// ****************************************************************
// Status register fields
// ****************************************************************
`define PFIF_ST_ANY_BIT 7
`define PFIF_ST_WP_ON_BIT 6
`define PFIF_ST_FIN_BIT 5

// ****************************************************************
// Fault control register fields
// ****************************************************************
`define PFIF_FC_IN_EN_LSB 0
`define PFIF_FC_FILT_EN_LSB 4
`define PFIF_FC_FAULT_FILTER_VALUE_LSB 8

// ****************************************************************
// Mode register fields
// ****************************************************************
`define PFIF_MD_FCTRL_BIT 0
`define PFIF_MD_WPOFF_BIT 2
`define PFIF_MD_POL_LSB 4

// ****************************************************************
// Reset values
// ****************************************************************
`define PFIF_RST_CHAN_FILT 16'h0000
`define PFIF_RST_FAULT_FILTER_VALUE 4'h0
`define PFIF_RST_EN 4'h0
`define PFIF_RST_POL 4'h0
`define PFIF_RST_WPOFF 1'b1

`endif

// file: pkg/pfif_pkg.sv
// Types shared by the fault/filter block
package pfif_pkg;

  typedef struct packed {
    logic [3:0] fault_filter_value;
    logic [3:0] filt_en;
    logic [3:0] in_en;
  } pfif_fault_ctrl_t;

  typedef struct packed {
    logic [3:0] pol;
    logic wp_off;
    logic fault_ctrl_en;
  } pfif_mode_t;

  typedef enum logic {
    PFIF_BUS_IDLE = 1'b0,
    PFIF_BUS_ANSWER = 1'b1
  } pfif_bus_st_t;

endpackage : pfif_pkg

// file: core/pfif_top.sv
// Fault flags, write protection and input filters of the PWM timer
`timescale 1ns/1ns
`include "pfif_regs.svh"

module pfif_top #(
  parameter int NFAULT = 4,
  parameter int NCHAN = 8
) (
  input wire logic i_core_clk, // System clock
  input wire logic i_srst, // Synchronous reset, high
  input wire logic [7:0] i_avs_address, // Byte address
  input wire logic i_avs_read, // Read request
  input wire logic i_avs_write, // Write request
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte lanes
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Stall, high
  input wire logic [NFAULT-1:0] i_fault_in, // Fault pins
  input wire logic [NCHAN-1:0] i_chan_in, // Channel input pins
  output logic [NCHAN-1:0] o_chan_filt, // Channel inputs: 3:0 filtered, upper ones only registered
  output logic [NFAULT-1:0] o_fault_flag, // Per-input fault flags
  output logic o_fault_any, // Summary fault flag
  output logic o_fault_inputs_or, // Live OR of enabled faults
  output logic o_write_protect_off, // Protection lifted
  output logic o_fault_ctrl_en // Fault control enabled
);

  // ****************************************************************
  // State
  // ****************************************************************
  pfif_pkg::pfif_bus_st_t st_ff, nxt_st;
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [15:0] chan_fval_ff, nxt_chan_fval;
  pfif_pkg::pfif_fault_ctrl_t fctrl_ff, nxt_fctrl;
  pfif_pkg::pfif_mode_t mode_ff, nxt_mode;
  logic wp_arm_ff, nxt_wp_arm;
  logic [NFAULT-1:0] flag_ff, nxt_flag;
  logic [NFAULT-1:0] arm_ff, nxt_arm;
  logic arm_any_ff, nxt_arm_any;
  logic any_ff, nxt_any;
  logic fin_ff, nxt_fin;
  logic [NCHAN-1:4] chan_hi_ff, nxt_chan_hi;

  localparam int NFILT = 4 + NFAULT;
  logic [NFILT-1:0] filt_in;
  logic [NFILT-1:0] filt_out;
  logic [3:0] filt_val [NFILT];

  logic req;
  logic rd_acc;
  logic wr_acc;
  logic [NFAULT-1:0] det;
  logic [31:0] rd_mux;
  logic prot_ok;

  // ****************************************************************
  // Filters: four channels then the fault inputs
  // ****************************************************************
  always_comb begin
    filt_in[3:0] = i_chan_in[3:0];
    filt_in[NFILT-1:4] = i_fault_in ^ mode_ff.pol;
    for (int i = 0; i < 4; i++) begin
      filt_val[i] = chan_fval_ff[4*i +: 4];
    end
    for (int j = 0; j < NFAULT; j++) begin
      filt_val[4+j] = fctrl_ff.filt_en[j] ? fctrl_ff.fault_filter_value : 4'h0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NFILT; g++) begin : g_filt
      logic [3:0] cnt_ff, nxt_cnt;
      logic out_ff, nxt_out;
      always_comb begin
        nxt_cnt = 4'h0;
        nxt_out = out_ff;
        if (filt_val[g] == 4'h0) begin
          nxt_out = filt_in[g];
        end else if (filt_in[g] != out_ff) begin
          if (4'(cnt_ff + 4'h1) == filt_val[g]) begin
            nxt_out = filt_in[g];
          end else begin
            nxt_cnt = 4'(cnt_ff + 4'h1);
          end
        end
      end
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          cnt_ff <= 4'h0;
          out_ff <= 1'b0;
        end else begin
          cnt_ff <= nxt_cnt;
          out_ff <= nxt_out;
        end
      end
      assign filt_out[g] = out_ff;
    end
  endgenerate

  // ****************************************************************
  // Fault detection and read multiplexer
  // ****************************************************************
  always_comb begin
    det = {NFAULT{mode_ff.fault_ctrl_en}} & fctrl_ff.in_en &
          filt_out[NFILT-1:4];
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      `PFIF_OFS_STATUS: begin
        rd_mux[NFAULT-1:0] = flag_ff;
        rd_mux[`PFIF_ST_FIN_BIT] = fin_ff;
        rd_mux[`PFIF_ST_WP_ON_BIT] = ~mode_ff.wp_off;
        rd_mux[`PFIF_ST_ANY_BIT] = any_ff;
      end
      `PFIF_OFS_CHAN_FILT: rd_mux[15:0] = chan_fval_ff;
      `PFIF_OFS_FAULT_CTRL: begin
        rd_mux[`PFIF_FC_IN_EN_LSB +: 4] = fctrl_ff.in_en;
        rd_mux[`PFIF_FC_FILT_EN_LSB +: 4] = fctrl_ff.filt_en;
        rd_mux[`PFIF_FC_FAULT_FILTER_VALUE_LSB +: 4] = fctrl_ff.fault_filter_value;
      end
      `PFIF_OFS_MODE: begin
        rd_mux[`PFIF_MD_FCTRL_BIT] = mode_ff.fault_ctrl_en;
        rd_mux[`PFIF_MD_WPOFF_BIT] = mode_ff.wp_off;
        rd_mux[`PFIF_MD_POL_LSB +: 4] = mode_ff.pol;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Bus slave: one wait state, action at the answer edge
  // ****************************************************************
  always_comb begin
    req = i_avs_read | i_avs_write;
    rd_acc = (st_ff == pfif_pkg::PFIF_BUS_ANSWER) & i_avs_read;
    wr_acc = (st_ff == pfif_pkg::PFIF_BUS_ANSWER) & i_avs_write;
    nxt_st = pfif_pkg::PFIF_BUS_IDLE;
    nxt_wait = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (st_ff)
      pfif_pkg::PFIF_BUS_IDLE: begin
        if (req) begin
          nxt_st = pfif_pkg::PFIF_BUS_ANSWER;
          nxt_wait = 1'b0;
          nxt_rdata = i_avs_read ? rd_mux : 32'h0000_0000;
        end
      end
      pfif_pkg::PFIF_BUS_ANSWER: nxt_st = pfif_pkg::PFIF_BUS_IDLE;
      default: nxt_st = pfif_pkg::PFIF_BUS_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers, protection and fault flags
  // ****************************************************************
  always_comb begin
    nxt_chan_fval = chan_fval_ff;
    nxt_fctrl = fctrl_ff;
    nxt_mode = mode_ff;
    nxt_wp_arm = wp_arm_ff;
    nxt_arm = arm_ff;
    nxt_arm_any = arm_any_ff;
    nxt_flag = flag_ff;
    prot_ok = mode_ff.wp_off;
    nxt_chan_hi = i_chan_in[NCHAN-1:4];

    // Read-while-set arms the clear sequences
    if (rd_acc && i_avs_address == `PFIF_OFS_STATUS) begin
      nxt_arm = arm_ff | rdata_ff[NFAULT-1:0];
      nxt_arm_any = arm_any_ff | rdata_ff[`PFIF_ST_ANY_BIT];
      nxt_wp_arm = wp_arm_ff | rdata_ff[`PFIF_ST_WP_ON_BIT];
    end

    if (wr_acc) begin
      case (i_avs_address)
        `PFIF_OFS_STATUS: begin
          if (i_avs_byteenable[0]) begin
            if (i_avs_writedata[`PFIF_ST_WP_ON_BIT]) begin
              nxt_mode.wp_off = 1'b0;
              nxt_wp_arm = 1'b0;
            end
            if (!i_avs_writedata[`PFIF_ST_ANY_BIT] && arm_any_ff &&
                det == '0) begin
              nxt_flag = '0;
              nxt_arm = '0;
              nxt_arm_any = 1'b0;
            end
            for (int j = 0; j < NFAULT; j++) begin
              if (!i_avs_writedata[j] && arm_ff[j] && !det[j]) begin
                nxt_flag[j] = 1'b0;
                nxt_arm[j] = 1'b0;
              end
            end
          end
        end
        `PFIF_OFS_CHAN_FILT: begin
          if (i_avs_byteenable[0]) begin
            nxt_chan_fval[7:0] = i_avs_writedata[7:0];
          end
          if (i_avs_byteenable[1]) begin
            nxt_chan_fval[15:8] = i_avs_writedata[15:8];
          end
        end
        `PFIF_OFS_FAULT_CTRL: begin
          if (i_avs_byteenable[0] && prot_ok) begin
            nxt_fctrl.in_en = i_avs_writedata[`PFIF_FC_IN_EN_LSB +: 4];
            nxt_fctrl.filt_en = i_avs_writedata[`PFIF_FC_FILT_EN_LSB +: 4];
          end
          if (i_avs_byteenable[1]) begin
            nxt_fctrl.fault_filter_value = i_avs_writedata[`PFIF_FC_FAULT_FILTER_VALUE_LSB +: 4];
          end
        end
        `PFIF_OFS_MODE: begin
          if (i_avs_byteenable[0]) begin
            if (prot_ok) begin
              nxt_mode.fault_ctrl_en = i_avs_writedata[`PFIF_MD_FCTRL_BIT];
              nxt_mode.pol = i_avs_writedata[`PFIF_MD_POL_LSB +: 4];
            end
            if (i_avs_writedata[`PFIF_MD_WPOFF_BIT] && wp_arm_ff) begin
              nxt_mode.wp_off = 1'b1;
              nxt_wp_arm = 1'b0;
            end
          end
        end
        default: nxt_mode = mode_ff;
      endcase
    end

    // A detected fault sets its flag and restarts the sequences
    for (int j = 0; j < NFAULT; j++) begin
      if (det[j]) begin
        nxt_flag[j] = 1'b1;
        nxt_arm[j] = 1'b0;
      end
    end
    if (det != '0) begin
      nxt_arm_any = 1'b0;
    end
    nxt_any = |nxt_flag;
    nxt_fin = |det;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_ff <= pfif_pkg::PFIF_BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      chan_fval_ff <= `PFIF_RST_CHAN_FILT;
      fctrl_ff.fault_filter_value <= `PFIF_RST_FAULT_FILTER_VALUE;
      fctrl_ff.filt_en <= `PFIF_RST_EN;
      fctrl_ff.in_en <= `PFIF_RST_EN;
      mode_ff.pol <= `PFIF_RST_POL;
      mode_ff.wp_off <= `PFIF_RST_WPOFF;
      mode_ff.fault_ctrl_en <= 1'b0;
      wp_arm_ff <= 1'b0;
      arm_ff <= '0;
      arm_any_ff <= 1'b0;
      flag_ff <= '0;
      any_ff <= 1'b0;
      fin_ff <= 1'b0;
      chan_hi_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      chan_fval_ff <= nxt_chan_fval;
      fctrl_ff <= nxt_fctrl;
      mode_ff <= nxt_mode;
      wp_arm_ff <= nxt_wp_arm;
      arm_ff <= nxt_arm;
      arm_any_ff <= nxt_arm_any;
      flag_ff <= nxt_flag;
      any_ff <= nxt_any;
      fin_ff <= nxt_fin;
      chan_hi_ff <= nxt_chan_hi;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    o_avs_waitrequest = wait_ff;
    o_avs_readdata = rdata_ff;
    o_chan_filt = {chan_hi_ff, filt_out[3:0]};
    o_fault_flag = flag_ff;
    o_fault_any = any_ff;
    o_fault_inputs_or = fin_ff;
    o_write_protect_off = mode_ff.wp_off;
    o_fault_ctrl_en = mode_ff.fault_ctrl_en;
  end

endmodule : pfif_top

// file: dv/pfif_monitor.sv
// Port checker of the fault/filter block
`timescale 1ns/1ns
module pfif_monitor #(
  parameter int NFAULT = 4,
  parameter int NCHAN = 8
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [NFAULT-1:0] i_fault_in,
  input wire logic [NCHAN-1:0] i_chan_in,
  input wire logic [NCHAN-1:0] o_chan_filt,
  input wire logic [NFAULT-1:0] o_fault_flag,
  input wire logic o_fault_any,
  input wire logic o_fault_inputs_or,
  input wire logic o_write_protect_off,
  input wire logic o_fault_ctrl_en
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic ans;
  logic st_wr;
  logic md_wr;
  assign ans = !o_avs_waitrequest;
  assign st_wr = ans && i_avs_write && i_avs_address == 8'h74;
  assign md_wr = ans && i_avs_write && i_avs_address == 8'h80;
  // ****************************************************************
  // Bus answer shape
  // ****************************************************************
  sequence s_req;
    o_avs_waitrequest && (i_avs_read || i_avs_write);
  endsequence
  sequence s_answer;
    ##1 ans ##1 !ans;
  endsequence
  a_bus_answer: assert property (s_req |-> s_answer)
    else $error("bus answer not one cycle after request");
  a_idle_quiet: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
    else $error("read data not zero outside answer");
  // ****************************************************************
  // Flags and protection
  // ****************************************************************
  a_any_or: assert property (o_fault_any == |o_fault_flag)
    else $error("summary flag differs from input flags");
  a_flag_cause: assert property (!$past(i_srst) &&
    |(o_fault_flag & ~$past(o_fault_flag)) |-> $past(o_fault_ctrl_en))
    else $error("flag set without fault control");
  a_flag_clear: assert property (!$past(i_srst) &&
    |($past(o_fault_flag) & ~o_fault_flag) |-> $past(st_wr))
    else $error("flag cleared without status write");
  a_wp_on: assert property (!$past(i_srst) &&
    $fell(o_write_protect_off) |-> $past(st_wr && i_avs_writedata[6]))
    else $error("protection set without write of one");
  a_wp_off: assert property (!$past(i_srst) &&
    $rose(o_write_protect_off) |-> $past(md_wr && i_avs_writedata[2]))
    else $error("protection lifted without mode write");
  a_fin_ctrl: assert property (!$past(i_srst) &&
    o_fault_inputs_or |-> $past(o_fault_ctrl_en))
    else $error("fault input summary without fault control");
  a_rsvd_zero: assert property (ans && i_avs_read &&
    i_avs_address == 8'h74 |-> o_avs_readdata[31:8] == 24'h0 &&
    !o_avs_readdata[4] && o_avs_readdata[7] == |o_avs_readdata[3:0])
    else $error("status word reserved or summary bits wrong");
  a_ch_pass: assert property (!$past(i_srst) |->
    o_chan_filt[NCHAN-1:4] == $past(i_chan_in[NCHAN-1:4]))
    else $error("upper channels not one clock delayed");
endmodule : pfif_monitor

bind pfif_top pfif_monitor #(.NFAULT(NFAULT), .NCHAN(NCHAN)) u_mon (.*);

// file: dv/pfif_src.sv
// Model of fault sources and channel signals at the pins
`timescale 1ns/1ns
module pfif_src (
  input wire logic i_core_clk, // System clock
  input wire logic [3:0] i_fault_req, // Wanted fault levels
  input wire logic [7:0] i_chan_req, // Wanted channel levels
  output logic [3:0] o_fault_in, // Fault pins
  output logic [7:0] o_chan_in // Channel pins
);
  // Pins move just after an edge, synchronous to the clock
  initial begin
    o_fault_in = 4'h0;
    o_chan_in = 8'h00;
  end
  always @(posedge i_core_clk) begin
    o_fault_in <= i_fault_req;
    o_chan_in <= i_chan_req;
  end
endmodule : pfif_src

// file: dv/pfif_top_tb.sv
// Self-checking bench of the fault/filter block
`timescale 1ns/1ns
module pfif_top_tb;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] flt_req = 4'h0;
  logic [7:0] ch_req = 8'h00;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] fin;
  logic [7:0] cin;
  logic [7:0] filt;
  logic [3:0] flag;
  logic any;
  logic fior;
  logic wpoff;
  logic fcen;
  logic [5:0] pins;
  logic [31:0] rdat;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  assign pins = {any, fior, flag};
  always #20 i_core_clk = ~i_core_clk;
  pfif_src u_src (.i_core_clk(i_core_clk), .i_fault_req(flt_req),
    .i_chan_req(ch_req), .o_fault_in(fin), .o_chan_in(cin));
  pfif_top dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_fault_in(fin), .i_chan_in(cin), .o_chan_filt(filt),
    .o_fault_flag(flag), .o_fault_any(any), .o_fault_inputs_or(fior),
    .o_write_protect_off(wpoff), .o_fault_ctrl_en(fcen));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_core_clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge i_core_clk); while (wreq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Let the answer edge settle before callers look at outputs
    @(posedge i_core_clk);
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd_chk
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rd_chk(8'h74, 32'h0);
    rd_chk(8'h7c, 32'h0);
    rd_chk(8'h10, 32'h0);
    chk({31'h0, wpoff}, 32'h1);
    bus(1'b1, 8'h78, 32'hffff_4321);
    rd_chk(8'h78, 32'h4321);
    bus(1'b1, 8'h7c, 32'hffff_fa5f);
    rd_chk(8'h7c, 32'ha5f);
  endtask : t_regs
  task automatic t_chan;
    bus(1'b1, 8'h78, 32'h3);
    ch_req <= 8'hff;
    cyc(3);
    chk({24'h0, filt}, 32'hfe);
    cyc(4);
    chk({24'h0, filt}, 32'hff);
    ch_req <= 8'h00;
    cyc(2);
    ch_req <= 8'hff;
    cyc(3);
    chk({24'h0, filt}, 32'hff);
  endtask : t_chan
  task automatic t_flags;
    bus(1'b1, 8'h80, 32'h5);
    bus(1'b1, 8'h7c, 32'hf);
    flt_req <= 4'h1;
    cyc(4);
    chk({26'h0, pins}, 32'h31);
    rd_chk(8'h74, 32'ha1);
    bus(1'b1, 8'h74, 32'h0);
    chk({26'h0, pins}, 32'h31);
    flt_req <= 4'h0;
    cyc(4);
    bus(1'b1, 8'h74, 32'h0);
    chk({26'h0, pins}, 32'h21);
    rd_chk(8'h74, 32'h81);
    bus(1'b1, 8'h74, 32'h0);
    chk({26'h0, pins}, 32'h0);
    flt_req <= 4'h3;
    cyc(4);
    flt_req <= 4'h0;
    cyc(4);
    rd_chk(8'h74, 32'h83);
    bus(1'b1, 8'h74, 32'h82);
    chk({26'h0, pins}, 32'h22);
    bus(1'b1, 8'h74, 32'h80);
    chk({26'h0, pins}, 32'h0);
  endtask : t_flags
  task automatic t_pol_en;
    bus(1'b1, 8'h7c, 32'hb);
    flt_req <= 4'h4;
    cyc(4);
    chk({26'h0, pins}, 32'h0);
    bus(1'b1, 8'h80, 32'h4);
    flt_req <= 4'h1;
    cyc(4);
    chk({26'h0, pins}, 32'h0);
    flt_req <= 4'h0;
    bus(1'b1, 8'h80, 32'h15);
    cyc(4);
    chk({26'h0, pins}, 32'h31);
    flt_req <= 4'h1;
    cyc(4);
    rd_chk(8'h74, 32'h81);
    bus(1'b1, 8'h74, 32'h0);
    chk({26'h0, pins}, 32'h0);
  endtask : t_pol_en
  task automatic t_ffilt;
    bus(1'b1, 8'h80, 32'h4);
    flt_req <= 4'h0;
    bus(1'b1, 8'h7c, 32'h31f);
    bus(1'b1, 8'h80, 32'h5);
    flt_req <= 4'h3;
    cyc(2);
    flt_req <= 4'h0;
    cyc(5);
    chk({26'h0, pins}, 32'h22);
    rd_chk(8'h74, 32'h82);
    bus(1'b1, 8'h74, 32'h0);
    flt_req <= 4'h1;
    cyc(8);
    chk({26'h0, pins}, 32'h31);
    flt_req <= 4'h0;
  endtask : t_ffilt
  task automatic t_protect;
    bus(1'b1, 8'h74, 32'h40);
    chk({31'h0, wpoff}, 32'h0);
    bus(1'b1, 8'h7c, 32'h0);
    rd_chk(8'h7c, 32'h1f);
    bus(1'b1, 8'h80, 32'h4);
    chk({30'h0, wpoff, fcen}, 32'h1);
    rd_chk(8'h74, 32'hc1);
    bus(1'b1, 8'h80, 32'h4);
    chk({31'h0, wpoff}, 32'h1);
    bus(1'b1, 8'h74, 32'h1);
    chk({31'h0, wpoff}, 32'h1);
  endtask : t_protect
  // ****************************************************************
  // Main sequence and timeout
  // ****************************************************************
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict;
    end
  end
  initial begin
    cyc(2);
    i_srst <= 1'b0;
    t_regs;
    t_chan;
    t_flags;
    t_pol_en;
    t_ffilt;
    t_protect;
    print_verdict;
  end
endmodule : pfif_top_tb
